/* File: hw/adc_output_reset_clip_control.sv */
// reset/power-down sequencer, overrange flags and filter enable of the converter back end
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
// ****************************************
// Functional notes
// R1: filter_bypass low filters, high bypasses all
// R2: filter only acts in PCM output mode
// R3: filter corner equals fs over 48000
// R4: four overrange flags, channels one to four
// R5: flag rises at once on excursion
// R6: hold lasts 256 times N sample periods
// R7: no new excursion: flag drops at end
// R8: after power-on, wait for active clock
// R9: every initialization lasts 1024 clock periods
// R10: data low during init, enabled after
// R11: reset rising edge restarts initialization anytime
// R12: controller holds reset low 40ns minimum
// R13: 65536 low cycles enter power-down
// R14: power-down stops clocks, data held low
// R15: controller restarts clocks before releasing reset
// R16: leaving power-down runs full initialization
// R17: shorter low period is plain reset
// R18: new excursion restarts the hold count
// ****************************************
module adc_output_reset_clip_control
    import adc_ctrl_pkg::*;
#(
    parameter int DATA_W      = 24,
    parameter int PDOWN_LEN   = adc_ctrl_pkg::PDOWN_PERIODS,
    parameter int HOLD_MULT   = adc_ctrl_pkg::HOLD_BASE,
    parameter int INIT_LEN    = adc_ctrl_pkg::INIT_PERIODS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              system_clock_in,
    input  wire logic              reset_pin_n,
    input  wire logic              filter_bypass,
    input  wire logic              sample_tick,
    input  wire logic [3:0]        decim_overrange,
    input  wire logic [DATA_W-1:0] adc_data_in,
    output logic      [DATA_W-1:0] adc_data_out,
    output logic                   data_out_enable,
    output logic                   internal_clk_run,
    output logic                   hpf_enable,
    output logic      [15:0]       hpf_corner_div,
    output logic                   overrange_flag_ch1,
    output logic                   overrange_flag_ch2,
    output logic                   overrange_flag_ch3,
    output logic                   overrange_flag_ch4,
    output logic                   irq
);
    import adc_ctrl_pkg::*;

    // ****************************************
    // system clock sampling and activity
    // ****************************************
    logic        sck_q;
    logic        sck_rise;
    logic [7:0]  loss_cnt_q;
    logic        sck_active_q;

    assign sck_rise = system_clock_in & ~sck_q;
    // the clock counts as lost after a window of pclk cycles with no rise

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q        <= 1'b0;
            loss_cnt_q   <= 8'h00;
            sck_active_q <= 1'b0;
        end else begin
            sck_q <= system_clock_in;
            if (sck_rise) begin
                loss_cnt_q   <= 8'h00;
                sck_active_q <= 1'b1; // R8
            end else if (loss_cnt_q == 8'(SCK_LOSS_CYC - 1)) begin
                sck_active_q <= 1'b0;
            end else begin
                loss_cnt_q <= loss_cnt_q + 8'h01;
            end
        end
    end

    // ****************************************
    // reset and power-down sequencer
    // ****************************************
    seq_state_t  state_q;
    logic        rst_pin_q;
    logic [2:0]  low_ns_cnt_q;
    logic [16:0] low_cnt_q;
    logic [10:0] init_cnt_q;
    logic        init_done_ev;
    logic        pdown_ev;

    // a low too short to meet the minimum width is treated as a glitch and ignored
    // lows are timed in pclk cycles, the power-down span in system clock rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q      <= ST_WAIT_CLK;
            rst_pin_q    <= 1'b1;
            low_ns_cnt_q <= 3'h0;
            low_cnt_q    <= 17'h0_0000;
            init_cnt_q   <= 11'h000;
        end else begin
            rst_pin_q <= reset_pin_n;
            if (!reset_pin_n) begin
                if (low_ns_cnt_q != 3'(RST_MIN_CYC))
                    low_ns_cnt_q <= low_ns_cnt_q + 3'h1;
                if (sck_rise && low_cnt_q != 17'(PDOWN_LEN))
                    low_cnt_q <= low_cnt_q + 17'h0_0001; // R17
            end else begin
                low_ns_cnt_q <= 3'h0;
                low_cnt_q    <= 17'h0_0000;
            end
            unique case (state_q)
                ST_WAIT_CLK: begin
                    init_cnt_q <= 11'h000;
                    if (sck_active_q && reset_pin_n)
                        state_q <= ST_INIT; // R8
                end
                ST_INIT, ST_RUN: begin
                    if (state_q == ST_INIT && sck_rise)
                        init_cnt_q <= init_cnt_q + 11'h001;
                    if (state_q == ST_INIT && init_cnt_q == 11'(INIT_LEN))
                        state_q <= ST_RUN; // R9
                    if (!reset_pin_n && low_ns_cnt_q == 3'(RST_MIN_CYC - 1))
                        state_q <= ST_RST_LOW; // R12
                end
                ST_RST_LOW: begin
                    init_cnt_q <= 11'h000;
                    // a stopped clock never reaches power-down, as no rise is counted
                    if (low_cnt_q == 17'(PDOWN_LEN))
                        state_q <= ST_PDOWN; // R13
                    else if (reset_pin_n && !rst_pin_q)
                        state_q <= sck_active_q ? ST_INIT : ST_WAIT_CLK; // R11 R17
                end
                ST_PDOWN: begin
                    init_cnt_q <= 11'h000;
                    // the controller brings the clocks back before release
                    if (reset_pin_n && sck_active_q)
                        state_q <= ST_INIT; // R15 R16
                end
                default: state_q <= ST_WAIT_CLK;
            endcase
        end
    end

    assign init_done_ev = (state_q == ST_INIT) && (init_cnt_q == 11'(INIT_LEN));
    assign pdown_ev     = (state_q == ST_RST_LOW) && (low_cnt_q == 17'(PDOWN_LEN));

    // ****************************************
    // control register and output stage
    // ****************************************
    logic [2:0] ctrl_q;
    logic       dsd_mode;
    logic       running;
    logic       wr_en;

    assign dsd_mode = ctrl_q[CTRL_DSD_BIT];
    assign running  = (state_q == ST_RUN);
    assign wr_en    = psel & penable & pready & pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_data_out     <= '0;
            data_out_enable  <= 1'b0;
            internal_clk_run <= 1'b0;
            hpf_enable       <= 1'b0;
            hpf_corner_div   <= 16'h0000;
        end else begin
            adc_data_out     <= running ? adc_data_in : '0; // R10 R14
            data_out_enable  <= running; // R10
            internal_clk_run <= (state_q != ST_PDOWN); // R14
            hpf_enable       <= running & ~filter_bypass & ~dsd_mode; // R1 R2
            // downstream filter divides the sample rate by this to place its corner
            hpf_corner_div   <= 16'(HPF_CORNER_DIV); // R3
        end
    end

    // ****************************************
    // overrange flags
    // ****************************************
    logic [17:0] hold_len;
    logic [3:0]  flag_q;
    logic [3:0]  flag_prev_q;
    logic [17:0] hold_cnt_q [4];

    // a rate change only applies to holds loaded after it
    always_comb begin
        unique case (rate_t'(ctrl_q[CTRL_RATE_LSB +: 2]))
            RATE_SINGLE: hold_len = 18'(HOLD_MULT * N_SINGLE); // R6
            RATE_DUAL:   hold_len = 18'(HOLD_MULT * N_DUAL);
            RATE_QUAD, RATE_QUAD_ALT: hold_len = 18'(HOLD_MULT * N_QUAD);
        endcase
    end

    // hold timers count sample ticks; with no tick a flag stays high until power-down clears it
    for (genvar i = 0; i < 4; i++) begin : g_flag // R4
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_q[i]     <= 1'b0;
                hold_cnt_q[i] <= 18'h0_0000;
            end else if (state_q == ST_PDOWN) begin
                flag_q[i]     <= 1'b0;
                hold_cnt_q[i] <= 18'h0_0000;
            // an excursion outranks a tick, so a reload never leaves a gap
            end else if (decim_overrange[i]) begin
                flag_q[i]     <= 1'b1; // R5
                hold_cnt_q[i] <= hold_len; // R18
            end else if (sample_tick && hold_cnt_q[i] != 18'h0_0000) begin
                hold_cnt_q[i] <= hold_cnt_q[i] - 18'h0_0001;
                if (hold_cnt_q[i] == 18'h0_0001)
                    flag_q[i] <= 1'b0; // R7
            end
        end
    end

    assign overrange_flag_ch1 = flag_q[0];
    assign overrange_flag_ch2 = flag_q[1];
    assign overrange_flag_ch3 = flag_q[2];
    assign overrange_flag_ch4 = flag_q[3];

    // ****************************************
    // interrupts
    // ****************************************
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_en_q;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic             sck_active_prev_q;

    assign irq_set = {sck_active_prev_q & ~sck_active_q, pdown_ev, init_done_ev,
                      flag_q & ~flag_prev_q};
    assign irq_clr = (wr_en && paddr == IRQ_CLR_OFS) ? pwdata[IRQ_W-1:0] : '0;

    // a set in the same cycle as its clear wins
    // irq is built from the next status value, so it rises with the event
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q        <= '0;
            flag_prev_q       <= 4'h0;
            sck_active_prev_q <= 1'b0;
            irq               <= 1'b0;
        end else begin
            flag_prev_q       <= flag_q;
            sck_active_prev_q <= sck_active_q;
            irq_stat_q        <= (irq_stat_q & ~irq_clr) | irq_set;
            irq               <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    logic [31:0] rd_mux;
    logic        addr_ok;

    // unmapped offsets answer with an error and read as zero
    always_comb begin
        rd_mux  = 32'h0000_0000;
        addr_ok = 1'b1;
        unique case (paddr)
            CTRL_OFS:     rd_mux = {29'h0, ctrl_q};
            STATUS_OFS:   rd_mux = {25'h0, flag_q, sck_active_q,
                                    state_q == ST_PDOWN, state_q == ST_INIT};
            IRQ_STAT_OFS: rd_mux = {25'h0, irq_stat_q};
            IRQ_CLR_OFS:  rd_mux = 32'h0000_0000;
            IRQ_EN_OFS:   rd_mux = {25'h0, irq_en_q};
            default:      addr_ok = 1'b0;
        endcase
    end

    // one wait state: the answer is registered during the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~addr_ok;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q   <= CTRL_RESET;
            irq_en_q <= IRQ_EN_RESET;
        end else if (wr_en) begin
            if (paddr == CTRL_OFS)
                ctrl_q <= pwdata[2:0];
            if (paddr == IRQ_EN_OFS)
                irq_en_q <= pwdata[IRQ_W-1:0];
        end
    end
endmodule // adc_output_reset_clip_control

/* File: hw/adc_ctrl_pkg.sv */
// constants and types shared by the converter control block
package adc_ctrl_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS  = 10;
    localparam int RST_MIN_NS     = 40;
    localparam int RST_MIN_CYC    = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int INIT_PERIODS   = 1024;
    localparam int PDOWN_PERIODS  = 65536;
    localparam int SCK_LOSS_CYC   = 64;
    localparam int HOLD_BASE      = 256;
    localparam int N_SINGLE       = 128;
    localparam int N_DUAL         = 256;
    localparam int N_QUAD         = 512;
    localparam int HPF_CORNER_DIV = 48000;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_CLR_OFS  = 8'h0C;
    localparam logic [7:0] IRQ_EN_OFS   = 8'h10;
    localparam int CTRL_RATE_LSB = 0;
    localparam int CTRL_DSD_BIT  = 2;
    localparam logic [2:0] CTRL_RESET   = 3'h0;
    localparam logic [6:0] IRQ_EN_RESET = 7'h00;
    // irq bits: [3:0] overrange set, 4 init done, 5 power-down entry, 6 clock lost
    localparam int IRQ_W = 7;
    typedef enum logic [1:0] {RATE_SINGLE, RATE_DUAL, RATE_QUAD, RATE_QUAD_ALT} rate_t;
    typedef enum logic [2:0] {ST_WAIT_CLK, ST_INIT, ST_RUN, ST_RST_LOW, ST_PDOWN} seq_state_t;
endpackage

/* File: test/adc_output_reset_clip_control_checker.sv */
// port assertions for the converter control block
`timescale 1ns/100ps
module adc_ctrl_checker #(
    parameter int DATA_W = 24
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              reset_pin_n,
    input wire logic              filter_bypass,
    input wire logic              sample_tick,
    input wire logic [3:0]        decim_overrange,
    input wire logic [DATA_W-1:0] adc_data_in,
    input wire logic [DATA_W-1:0] adc_data_out,
    input wire logic              data_out_enable,
    input wire logic              internal_clk_run,
    input wire logic              hpf_enable,
    input wire logic [15:0]       hpf_corner_div,
    input wire logic              overrange_flag_ch1,
    input wire logic              overrange_flag_ch4
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_FLAG_SET: assert property (decim_overrange[0] && data_out_enable |=> overrange_flag_ch1)
        else $error("flag one not raised");
    AST_FLAG_CH4: assert property (decim_overrange[3] && data_out_enable |=> overrange_flag_ch4)
        else $error("flag four not raised");
    AST_FLAG_HOLD: assert property (overrange_flag_ch1 && !sample_tick && data_out_enable |=>
        overrange_flag_ch1)
        else $error("flag dropped without a tick");
    AST_FLAG_DROP: assert property ($fell(overrange_flag_ch1) |-> $past(sample_tick) || !internal_clk_run)
        else $error("flag fell off a tick");
    AST_IDLE_LOW: assert property (!data_out_enable && !$past(data_out_enable) |-> adc_data_out == '0)
        else $error("data not low while idle");
    AST_DATA_PASS: assert property (data_out_enable && $past(data_out_enable) |->
        adc_data_out == $past(adc_data_in))
        else $error("data not passed through");
    AST_INIT_MIN: assert property ($rose(reset_pin_n) && !data_out_enable |=> !data_out_enable [*8])
        else $error("init ended too soon");
    AST_PD_QUIET: assert property (!internal_clk_run |-> !data_out_enable && adc_data_out == '0)
        else $error("outputs live in power-down");
    AST_PD_CAUSE: assert property ($fell(internal_clk_run) |-> !reset_pin_n)
        else $error("power-down without reset low");
    AST_BYPASS: assert property (filter_bypass |=> !hpf_enable)
        else $error("filter on while bypassed");
    AST_CORNER: assert property ($past(presetn) && $past(presetn, 2) |-> hpf_corner_div == 16'hBB80)
        else $error("corner divisor wrong");
endmodule // adc_ctrl_checker
bind adc_output_reset_clip_control adc_ctrl_checker #(.DATA_W(DATA_W)) chk_i (.pclk, .presetn,
    .reset_pin_n, .filter_bypass, .sample_tick, .decim_overrange, .adc_data_in, .adc_data_out,
    .data_out_enable, .internal_clk_run, .hpf_enable, .hpf_corner_div, .overrange_flag_ch1,
    .overrange_flag_ch4);

/* File: test/sys_ctrl_model.sv */
// system controller model: system clock and reset pin
`timescale 1ns/100ps
module sys_ctrl_model (
    input  wire logic pclk,
    input  wire logic clk_on,
    input  wire logic hold_low,
    output logic      system_clock_in,
    output logic      reset_pin_n
);
    logic tgl_q = 1'b0;
    logic rst_q = 1'b1;
    // a stopped clock stands at 0 so no period is counted
    always @(posedge pclk) tgl_q <= clk_on & ~tgl_q;
    always @(posedge pclk) rst_q <= !hold_low;
    assign system_clock_in = tgl_q;
    assign reset_pin_n     = rst_q;
endmodule // sys_ctrl_model

/* File: test/adc_output_reset_clip_control_test.sv */
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_output_reset_clip_control_test;
    import adc_ctrl_pkg::*;
    localparam int INIT_L = 16;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slv;
    logic        filter_bypass, sample_tick, data_out_enable, internal_clk_run, hpf_enable;
    logic        system_clock_in, reset_pin_n, clk_on, hold_low;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  decim_overrange, f;
    logic [23:0] adc_data_in = 24'h00_0000;
    logic [23:0] adc_data_out;
    logic [15:0] hpf_corner_div;
    int          bad_count, samples_checked, cyc, n;
    int          nv[4] = '{N_SINGLE, N_DUAL, N_QUAD, N_QUAD};
    adc_output_reset_clip_control #(.PDOWN_LEN(40), .INIT_LEN(INIT_L), .HOLD_MULT(1)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .system_clock_in, .reset_pin_n, .filter_bypass, .sample_tick, .decim_overrange,
        .adc_data_in, .adc_data_out, .data_out_enable, .internal_clk_run, .hpf_enable,
        .hpf_corner_div, .overrange_flag_ch1(f[0]), .overrange_flag_ch2(f[1]),
        .overrange_flag_ch3(f[2]), .overrange_flag_ch4(f[3]), .irq);
    sys_ctrl_model ctl (.pclk, .clk_on, .hold_low, .system_clock_in, .reset_pin_n);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge pclk);
    endtask
    task automatic wait_on;
        n = 0;
        while (data_out_enable !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // ticks until the flag of channel ch drops; a second excursion after tick again
    task automatic hold(input int ch, input int again, input int exp);
        decim_overrange <= 4'h1 << ch;
        @(posedge pclk);
        decim_overrange <= 4'h0;
        @(posedge pclk);
        chk(f, 4'h1 << ch);
        n = 0;
        while (f[ch] === 1'b1 && n < 2000) begin
            sample_tick <= 1'b1;
            @(posedge pclk);
            sample_tick <= 1'b0;
            @(posedge pclk);
            n++;
            if (n == again) hold_again(ch);
        end
        chk(n, exp);
    endtask
    task automatic hold_again(input int ch);
        decim_overrange <= 4'h1 << ch;
        @(posedge pclk);
        decim_overrange <= 4'h0;
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) adc_data_in <= adc_data_in + 24'h1;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, filter_bypass, sample_tick} = '0;
        {decim_overrange, clk_on, hold_low, bad_count, samples_checked} = '0;
        presetn = 1'b0;
        cycles(5);
        presetn <= 1'b1;
        cycles(30);
        chk(data_out_enable, 1'b0);
        clk_on <= 1'b1;
        wait_on();
        chk(n >= 2 * INIT_L && n <= 2 * INIT_L + 12, 1'b1);
        chk(hpf_corner_div, 16'hBB80);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h0000_0010);
        chk(irq, 1'b0);
        apb(1'b1, IRQ_EN_OFS, 32'h0000_007F);
        apb(1'b0, IRQ_EN_OFS, 32'h0);
        chk(rd, 32'h0000_007F);
        chk(irq, 1'b1);
        apb(1'b1, IRQ_CLR_OFS, 32'h0000_0010);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, slv}, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, CTRL_OFS, r);
            hold(r, -1, nv[r]);
        end
        hold(0, 50, 562);
        apb(1'b1, CTRL_OFS, 32'h0);
        cycles(2);
        chk(hpf_enable, 1'b1);
        filter_bypass <= 1'b1;
        cycles(2);
        chk(hpf_enable, 1'b0);
        filter_bypass <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h0000_0004);
        cycles(2);
        chk(hpf_enable, 1'b0);
        apb(1'b1, CTRL_OFS, 32'h0);
        hold_low <= 1'b1;
        cycles(2);
        hold_low <= 1'b0;
        cycles(10);
        chk(data_out_enable, 1'b1);
        hold_low <= 1'b1;
        cycles(10);
        chk(data_out_enable, 1'b0);
        hold_low <= 1'b0;
        wait_on();
        chk(n >= 2 * INIT_L && n <= 2 * INIT_L + 12, 1'b1);
        hold_low <= 1'b1;
        cycles(120);
        chk(internal_clk_run, 1'b0);
        clk_on <= 1'b0;
        cycles(20);
        chk({internal_clk_run, adc_data_out}, 25'h0);
        clk_on <= 1'b1;
        cycles(4);
        hold_low <= 1'b0;
        wait_on();
        chk(data_out_enable, 1'b1);
        apb(1'b0, IRQ_STAT_OFS, 32'h0);
        chk(rd, 32'h0000_003F);
        complete_run();
    end
endmodule // adc_output_reset_clip_control_test
